// [pkg/nbi_defs.svh]
// Constants for the NPU boundary interface ends
// Behaviour
// - Hard reset is asynchronous, active low
// - Asynchronous memory-test reset
// - Privilege taken from strap after reset
// - Security taken from strap after reset
// - Interrupt is an active-high level
// - Clock active raised while clock needed
// - Low request asks to gate clock
// - Clock request answered by accept or deny
// - Power active raised while power needed
// - Low request asks to power down
// - Power request answered by accept or deny
// - Port frozen while clock enable low
// - Wake-up raised while work pending
// - AXI4-compatible subset plus enable and wake-up
// - Write address: id, address, length, attributes
// - Write data 64 bits, 8 strobes, last
// - Write response id and code, device ready
// - Read address: id, address, length, attributes
// - Read ids chosen by fetched stream
// - Id ranges per stream fixed
// - Register wake-up ORed into clock active
`ifndef NBI_DEFS_SVH
`define NBI_DEFS_SVH
`define NBI_ID_W      6
`define NBI_ADDR_W    32
`define NBI_LEN_W     8
`define NBI_DATA_W    64
`define NBI_STRB_W    8
`define NBI_FIFO_DEPTH 8
`define NBI_MAX_OUT   8
`define NBI_SIZE_8B   3'h3
`define NBI_BURST_INCR 2'h1
`define NBI_CACHE_DEF 4'h3
`define NBI_CMD_FIRST  7'h00
`define NBI_CMD_LAST   7'h03
`define NBI_IFM_FIRST  7'h04
`define NBI_IFM_LAST   7'h1d
`define NBI_WGT_FIRST  7'h1e
`define NBI_WGT_LAST   7'h37
`define NBI_BIAS_FIRST 7'h38
`define NBI_BIAS_LAST  7'h3b
`define NBI_M2M_FIRST  7'h3c
`define NBI_M2M_LAST   7'h3f
`endif

// [pkg/nbi_pkg.sv]
// Types shared by both ends of the NPU boundary interface
package nbi_pkg;
  typedef enum logic [2:0] {
    NBI_STREAM_CMD,
    NBI_STREAM_IFM,
    NBI_STREAM_WGT,
    NBI_STREAM_BIAS,
    NBI_STREAM_M2M
  } nbi_stream_t;

  typedef enum logic [1:0] {
    NBI_Q_RUN,
    NBI_Q_GRANT,
    NBI_Q_DENY
  } nbi_qstate_t;
endpackage

// [pkg/nbi_if.sv]
// Boundary signals between the NPU end and the system end
`timescale 1ns/10ps
`include "nbi_defs.svh"
interface nbi_if;
  logic                     irq;
  logic                     clock_chan_active;
  logic                     clock_chan_request_n;
  logic                     clock_chan_accept_n;
  logic                     clock_chan_deny;
  logic                     power_chan_active;
  logic                     power_chan_request_n;
  logic                     power_chan_accept_n;
  logic                     power_chan_deny;
  logic                     mgr0_wakeup;
  logic                     mgr0_clock_enable;
  logic                     awvalid;
  logic [`NBI_ID_W-1:0]     awid;
  logic [`NBI_ADDR_W-1:0]   awaddr;
  logic [`NBI_LEN_W-1:0]    awlen;
  logic [2:0]               awsize;
  logic [1:0]               awburst;
  logic [3:0]               awcache;
  logic [2:0]               awprot;
  logic                     awready;
  logic                     wvalid;
  logic [`NBI_DATA_W-1:0]   wdata;
  logic [`NBI_STRB_W-1:0]   wstrb;
  logic                     wlast;
  logic                     wready;
  logic                     bvalid;
  logic [`NBI_ID_W-1:0]     bid;
  logic [1:0]               bresp;
  logic                     bready;
  logic                     arvalid;
  logic [`NBI_ID_W-1:0]     mgr0_read_id;
  logic [`NBI_ADDR_W-1:0]   araddr;
  logic [`NBI_LEN_W-1:0]    arlen;
  logic [2:0]               arsize;
  logic [1:0]               arburst;
  logic [3:0]               arcache;
  logic [2:0]               arprot;
  logic                     arready;

  modport dev (
    output irq, clock_chan_active, clock_chan_accept_n, clock_chan_deny,
    output power_chan_active, power_chan_accept_n, power_chan_deny, mgr0_wakeup,
    output awvalid, awid, awaddr, awlen, awsize, awburst, awcache, awprot,
    output wvalid, wdata, wstrb, wlast, bready,
    output arvalid, mgr0_read_id, araddr, arlen, arsize, arburst, arcache, arprot,
    input  clock_chan_request_n, power_chan_request_n, mgr0_clock_enable,
    input  awready, wready, bvalid, bid, bresp, arready
  );
  modport sys (
    input  irq, clock_chan_active, clock_chan_accept_n, clock_chan_deny,
    input  power_chan_active, power_chan_accept_n, power_chan_deny, mgr0_wakeup,
    input  awvalid, awid, awaddr, awlen, awsize, awburst, awcache, awprot,
    input  wvalid, wdata, wstrb, wlast, bready,
    input  arvalid, mgr0_read_id, araddr, arlen, arsize, arburst, arcache, arprot,
    output clock_chan_request_n, power_chan_request_n, mgr0_clock_enable,
    output awready, wready, bvalid, bid, bresp, arready
  );
endinterface

// [hdl/nbi_fifo.sv]
// Parameterised FIFO for write data beats
`timescale 1ns/10ps
module nbi_fifo #(
  parameter int WIDTH = 73,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("nbi_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic                        in_rdy;
    logic                        out_vld;
  } nbi_fifo_state_t;

  nbi_fifo_state_t s;
  nbi_fifo_state_t next_s;
  logic            push;
  logic            pop;

  assign in_ready  = s.in_rdy;
  assign out_valid = s.out_vld;
  assign out_data  = s.mem[s.rd];

  always_comb begin
    next_s = s;
    push   = in_valid && s.in_rdy;
    pop    = out_ready && s.out_vld;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr        = s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = s.rd + 1'b1;
    end
    // Full only reached when the drain side stalls
    next_s.cnt     = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    next_s.in_rdy  = next_s.cnt != (AW+1)'(DEPTH);
    next_s.out_vld = next_s.cnt != '0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s        <= '0;
      s.in_rdy <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end
endmodule

// [hdl/nbi_dev_end.sv]
// NPU end of the boundary: reset, straps, interrupt, Q-Channels, manager 0
`timescale 1ns/10ps
`include "nbi_defs.svh"
module nbi_dev_end
  import nbi_pkg::*;
#(
  parameter int FIFO_DEPTH = `NBI_FIFO_DEPTH,
  parameter int MAX_OUT    = `NBI_MAX_OUT
) (
  input  wire logic                     sys_clk,
  input  wire logic                     hard_reset_n,
  input  wire logic                     memtest_reset_n,
  input  wire logic                     boot_privilege_strap,
  input  wire logic                     boot_security_strap,
  input  wire logic                     regport_wakeup,
  input  wire logic                     need_clock,
  input  wire logic                     irq_event,
  input  wire logic                     irq_clear,
  input  wire logic                     wr_cmd_valid,
  output logic                          wr_cmd_ready,
  input  wire logic [`NBI_ID_W-1:0]     wr_cmd_id,
  input  wire logic [`NBI_ADDR_W-1:0]   wr_cmd_addr,
  input  wire logic [`NBI_LEN_W-1:0]    wr_cmd_len,
  input  wire logic                     wd_valid,
  output logic                          wd_ready,
  input  wire logic [`NBI_DATA_W-1:0]   wd_data,
  input  wire logic [`NBI_STRB_W-1:0]   wd_strb,
  input  wire logic                     wd_last,
  output logic                          wr_done,
  output logic [1:0]                    wr_done_resp,
  input  wire logic                     rd_cmd_valid,
  output logic                          rd_cmd_ready,
  input  wire nbi_stream_t              rd_cmd_stream,
  input  wire logic [4:0]               rd_cmd_slot,
  input  wire logic [`NBI_ADDR_W-1:0]   rd_cmd_addr,
  input  wire logic [`NBI_LEN_W-1:0]    rd_cmd_len,
  input  wire logic                     rd_done,
  output logic                          privileged,
  output logic                          nonsecure,
  nbi_if.dev                            port
);
  localparam int OW = $clog2(MAX_OUT + 1);
  localparam int FW = `NBI_DATA_W + `NBI_STRB_W + 1;

  initial begin
    if (MAX_OUT < 1 || FIFO_DEPTH < 2)
      $error("nbi_dev_end: MAX_OUT or FIFO_DEPTH too small");
  end

  typedef struct packed {
    logic                   strap_done;
    logic                   privileged;
    logic                   nonsecure;
    logic                   irq;
    logic                   awvalid;
    logic [`NBI_ID_W-1:0]   awid;
    logic [`NBI_ADDR_W-1:0] awaddr;
    logic [`NBI_LEN_W-1:0]  awlen;
    logic                   awrdy;
    logic                   wvalid;
    logic [`NBI_DATA_W-1:0] wdata;
    logic [`NBI_STRB_W-1:0] wstrb;
    logic                   wlast;
    logic                   bready;
    logic                   wr_done;
    logic [1:0]             wr_resp;
    logic                   arvalid;
    logic [`NBI_ID_W-1:0]   arid;
    logic [`NBI_ADDR_W-1:0] araddr;
    logic [`NBI_LEN_W-1:0]  arlen;
    logic                   ardy;
    logic [OW-1:0]          wr_out;
    logic [OW-1:0]          rd_out;
    nbi_qstate_t [1:0]      q;
    logic [1:0]             accept_n;
    logic [1:0]             deny;
    logic [1:0]             active;
    logic                   wakeup;
  } nbi_dev_state_t;

  nbi_dev_state_t   s;
  nbi_dev_state_t   next_s;
  logic             ce;
  logic             rst_n;
  logic             fifo_vld;
  logic             fifo_pop;
  logic [FW-1:0]    fifo_data;
  logic [1:0]       req_n;
  logic             busy;
  logic             aw_go;
  logic             ar_go;
  logic             b_go;

  // Either reset clears all state, FIFO included, except accept_n and the FIFO in_rdy, which are set high
  assign rst_n = hard_reset_n && memtest_reset_n;
  assign ce    = port.mgr0_clock_enable;
  assign req_n = {port.power_chan_request_n, port.clock_chan_request_n};

  // A slot past its range clamps to the last id
  function automatic logic [`NBI_ID_W-1:0] map_id(nbi_stream_t st, logic [4:0] slot);
    logic [6:0] first;
    logic [6:0] last;
    logic [6:0] id;
    case (st)
      NBI_STREAM_CMD:  {first, last} = {`NBI_CMD_FIRST, `NBI_CMD_LAST};
      NBI_STREAM_IFM:  {first, last} = {`NBI_IFM_FIRST, `NBI_IFM_LAST};
      NBI_STREAM_WGT:  {first, last} = {`NBI_WGT_FIRST, `NBI_WGT_LAST};
      NBI_STREAM_BIAS: {first, last} = {`NBI_BIAS_FIRST, `NBI_BIAS_LAST};
      default:         {first, last} = {`NBI_M2M_FIRST, `NBI_M2M_LAST};
    endcase
    id = first + {2'h0, slot};
    if (id > last) begin
      id = last;
    end
    return id[`NBI_ID_W-1:0];
  endfunction

  nbi_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_wfifo (
    .clk       (sys_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (wd_valid),
    .in_ready  (wd_ready),
    .in_data   ({wd_data, wd_strb, wd_last}),
    .out_valid (fifo_vld),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  assign fifo_pop = !s.wvalid || port.wready;

  always_comb begin
    next_s = s;
    aw_go  = wr_cmd_valid && s.awrdy;
    ar_go  = rd_cmd_valid && s.ardy;
    b_go   = port.bvalid && s.bready;
    // Straps caught once, at the first enabled edge
    if (!s.strap_done) begin
      next_s.strap_done = 1'b1;
      next_s.privileged = boot_privilege_strap;
      next_s.nonsecure  = boot_security_strap;
    end
    // Sticky interrupt level; a new event beats a clear
    if (irq_clear) begin
      next_s.irq = 1'b0;
    end
    if (irq_event) begin
      next_s.irq = 1'b1;
    end
    if (s.awvalid && port.awready) begin
      next_s.awvalid = 1'b0;
    end
    if (aw_go) begin
      next_s.awvalid = 1'b1;
      next_s.awid    = wr_cmd_id;
      next_s.awaddr  = wr_cmd_addr;
      next_s.awlen   = wr_cmd_len;
    end
    if (fifo_pop) begin
      next_s.wvalid = fifo_vld;
      next_s.wdata  = fifo_data[FW-1 -: `NBI_DATA_W];
      next_s.wstrb  = fifo_data[`NBI_STRB_W:1];
      next_s.wlast  = fifo_data[0];
    end
    next_s.bready  = 1'b1;
    next_s.wr_done = b_go;
    if (b_go) begin
      next_s.wr_resp = port.bresp;
    end
    if (s.arvalid && port.arready) begin
      next_s.arvalid = 1'b0;
    end
    if (ar_go) begin
      next_s.arvalid = 1'b1;
      next_s.arid    = map_id(rd_cmd_stream, rd_cmd_slot);
      next_s.araddr  = rd_cmd_addr;
      next_s.arlen   = rd_cmd_len;
    end
    next_s.wr_out = s.wr_out + OW'(aw_go) - OW'(b_go && s.wr_out != '0);
    next_s.rd_out = s.rd_out + OW'(ar_go) - OW'(rd_done && s.rd_out != '0);
    // Take a request only while its response has a slot
    next_s.awrdy = !next_s.awvalid && next_s.wr_out != OW'(MAX_OUT);
    next_s.ardy  = !next_s.arvalid && next_s.rd_out != OW'(MAX_OUT);
    busy = s.wr_out != '0 || s.rd_out != '0 || s.awvalid || s.arvalid
           || s.wvalid || fifo_vld;
    next_s.wakeup    = busy;
    next_s.active[0] = busy || s.irq || need_clock || regport_wakeup;
    next_s.active[1] = busy || s.irq || need_clock;
    for (int i = 0; i < 2; i++) begin
      case (s.q[i])
        NBI_Q_RUN: begin
          if (!req_n[i]) begin
            if (busy || s.irq || need_clock) begin
              next_s.q[i]    = NBI_Q_DENY;
              next_s.deny[i] = 1'b1;
            end else begin
              next_s.q[i]        = NBI_Q_GRANT;
              next_s.accept_n[i] = 1'b0;
            end
          end
        end
        NBI_Q_GRANT: begin
          // Held until the controller withdraws
          if (req_n[i]) begin
            next_s.q[i]        = NBI_Q_RUN;
            next_s.accept_n[i] = 1'b1;
          end
        end
        NBI_Q_DENY: begin
          if (req_n[i]) begin
            next_s.q[i]    = NBI_Q_RUN;
            next_s.deny[i] = 1'b0;
          end
        end
        default: begin
          next_s.q[i]        = NBI_Q_RUN;
          next_s.accept_n[i] = 1'b1;
          next_s.deny[i]     = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.accept_n <= 2'h3;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign wr_cmd_ready              = s.awrdy;
  assign rd_cmd_ready              = s.ardy;
  assign wr_done                   = s.wr_done;
  assign wr_done_resp              = s.wr_resp;
  assign privileged                = s.privileged;
  assign nonsecure                 = s.nonsecure;
  assign port.irq                  = s.irq;
  assign port.clock_chan_active    = s.active[0];
  assign port.clock_chan_accept_n  = s.accept_n[0];
  assign port.clock_chan_deny      = s.deny[0];
  assign port.power_chan_active    = s.active[1];
  assign port.power_chan_accept_n  = s.accept_n[1];
  assign port.power_chan_deny      = s.deny[1];
  assign port.mgr0_wakeup          = s.wakeup;
  assign port.awvalid              = s.awvalid;
  assign port.awid                 = s.awid;
  assign port.awaddr               = s.awaddr;
  assign port.awlen                = s.awlen;
  // Fixed size, burst and cache that AXI4 subordinates accept; protection bits from the straps
  assign port.awsize               = `NBI_SIZE_8B;
  assign port.awburst              = `NBI_BURST_INCR;
  assign port.awcache              = `NBI_CACHE_DEF;
  assign port.awprot               = {1'b0, s.nonsecure, s.privileged};
  assign port.wvalid               = s.wvalid;
  assign port.wdata                = s.wdata;
  assign port.wstrb                = s.wstrb;
  assign port.wlast                = s.wlast;
  assign port.bready               = s.bready;
  assign port.arvalid              = s.arvalid;
  assign port.mgr0_read_id         = s.arid;
  assign port.araddr               = s.araddr;
  assign port.arlen                = s.arlen;
  assign port.arsize               = `NBI_SIZE_8B;
  assign port.arburst              = `NBI_BURST_INCR;
  assign port.arcache              = `NBI_CACHE_DEF;
  assign port.arprot               = {1'b0, s.nonsecure, s.privileged};
endmodule

// [hdl/nbi_sys_end.sv]
// System end: write/read subordinate and clock and power controllers
`timescale 1ns/10ps
`include "nbi_defs.svh"
module nbi_sys_end
  import nbi_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  input  wire logic                   sub_clk_en,
  input  wire logic                   clock_gate_req,
  input  wire logic                   power_down_req,
  input  wire logic [1:0]             bresp_code,
  output logic                        clock_granted,
  output logic                        clock_denied,
  output logic                        power_granted,
  output logic                        power_denied,
  output logic                        irq_seen,
  output logic                        wr_seen,
  output logic [`NBI_ID_W-1:0]        wr_seen_id,
  output logic                        rd_seen,
  output logic [`NBI_ID_W-1:0]        rd_seen_id,
  nbi_if.sys                          port
);
  typedef struct packed {
    logic                 clk_en;
    logic [1:0]           req_n;
    logic [1:0]           granted;
    logic [1:0]           denied;
    logic                 irq;
    logic                 aw_busy;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [`NBI_ID_W-1:0] bid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 wr_seen;
    logic                 rd_seen;
    logic [`NBI_ID_W-1:0] rd_id;
  } nbi_sys_state_t;

  nbi_sys_state_t s;
  nbi_sys_state_t next_s;
  logic [1:0]     want;
  logic [1:0]     acc_n;
  logic [1:0]     dny;

  assign want  = {power_down_req, clock_gate_req};
  assign acc_n = {port.power_chan_accept_n, port.clock_chan_accept_n};
  assign dny   = {port.power_chan_deny, port.clock_chan_deny};

  always_comb begin
    next_s         = s;
    next_s.clk_en  = sub_clk_en;
    next_s.irq     = port.irq;
    next_s.granted = ~acc_n;
    next_s.denied  = dny;
    for (int i = 0; i < 2; i++) begin
      if (s.req_n[i]) begin
        // Request again only once the last handshake closed
        if (want[i] && acc_n[i] && !dny[i]) begin
          next_s.req_n[i] = 1'b0;
        end
      end else if (dny[i] || (!acc_n[i] && !want[i])) begin
        next_s.req_n[i] = 1'b1;
      end
    end
    next_s.wr_seen = 1'b0;
    next_s.rd_seen = 1'b0;
    if (s.clk_en) begin
      if (port.awvalid && s.awready) begin
        next_s.aw_busy = 1'b1;
        next_s.bid     = port.awid;
        next_s.wr_seen = 1'b1;
      end
      if (port.wvalid && s.wready && port.wlast) begin
        next_s.bvalid = 1'b1;
        next_s.bresp  = bresp_code;
      end
      if (s.bvalid && port.bready) begin
        next_s.bvalid  = 1'b0;
        next_s.aw_busy = 1'b0;
      end
      if (port.arvalid && s.arready) begin
        next_s.rd_seen = 1'b1;
        next_s.rd_id   = port.mgr0_read_id;
      end
      next_s.arready = 1'b1;
    end
    // One write burst at a time keeps response ordering trivial
    next_s.awready = !next_s.aw_busy;
    next_s.wready  = next_s.aw_busy && !next_s.bvalid;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s       <= '0;
      s.req_n <= 2'h3;
    end else begin
      s <= next_s;
    end
  end

  assign clock_granted             = s.granted[0];
  assign clock_denied              = s.denied[0];
  assign power_granted             = s.granted[1];
  assign power_denied              = s.denied[1];
  assign irq_seen                  = s.irq;
  assign wr_seen                   = s.wr_seen;
  assign wr_seen_id                = s.bid;
  assign rd_seen                   = s.rd_seen;
  assign rd_seen_id                = s.rd_id;
  assign port.mgr0_clock_enable    = s.clk_en;
  assign port.clock_chan_request_n = s.req_n[0];
  assign port.power_chan_request_n = s.req_n[1];
  assign port.awready              = s.awready;
  assign port.wready               = s.wready;
  assign port.bvalid               = s.bvalid;
  assign port.bid                  = s.bid;
  assign port.bresp                = s.bresp;
  assign port.arready              = s.arready;
endmodule

// [verification/nbi_assertions.sv]
// Checker on the boundary signals
`timescale 1ns/10ps
module nbi_assertions (
  input wire logic        sys_clk,
  input wire logic        hard_reset_n,
  input wire logic        memtest_reset_n,
  input wire logic        clock_chan_request_n,
  input wire logic        clock_chan_accept_n,
  input wire logic        clock_chan_deny,
  input wire logic        power_chan_request_n,
  input wire logic        power_chan_accept_n,
  input wire logic        power_chan_deny,
  input wire logic        mgr0_clock_enable,
  input wire logic        mgr0_wakeup,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] awaddr,
  input wire logic        wvalid,
  input wire logic        arvalid,
  input wire logic        irq,
  input wire logic        bvalid,
  input wire logic        bready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!(hard_reset_n && memtest_reset_n));
  property p_clk_ans; !clock_chan_accept_n |-> !$past(clock_chan_request_n); endproperty
  a_clk_ans: assert property (p_clk_ans) else $error("clock grant without request");
  property p_pwr_ans; (!power_chan_accept_n || power_chan_deny) |-> !$past(power_chan_request_n); endproperty
  a_pwr_ans: assert property (p_pwr_ans) else $error("power answer without request");
  property p_q_hold; (clock_chan_deny || !clock_chan_accept_n) && !clock_chan_request_n |=> clock_chan_deny || !clock_chan_accept_n; endproperty
  a_q_hold: assert property (p_q_hold) else $error("clock answer dropped early");
  property p_freeze; !mgr0_clock_enable |=> $stable(awvalid) && $stable(awaddr) && $stable(arvalid) && $stable(irq); endproperty
  a_freeze: assert property (p_freeze) else $error("output moved while disabled");
  property p_wake; (awvalid || arvalid) && mgr0_clock_enable |=> mgr0_wakeup; endproperty
  a_wake: assert property (p_wake) else $error("wakeup low with pending work");
  property p_aw_hold; awvalid && !awready |=> awvalid && $stable(awaddr); endproperty
  a_aw_hold: assert property (p_aw_hold) else $error("write address withdrawn");
  property p_bready; bvalid |-> bready; endproperty
  a_bready: assert property (p_bready) else $error("response not accepted");
  property p_idle; !clock_chan_accept_n |-> !irq && !awvalid && !arvalid && !wvalid; endproperty
  a_idle: assert property (p_idle) else $error("grant while busy");
endmodule

// [verification/tb_top.sv]
// Testbench joining both ends of the boundary
`timescale 1ns/10ps
module tb_top;
  import nbi_pkg::*;
  typedef struct {nbi_stream_t s; logic [4:0] slot; logic [5:0] id;} nbi_row_t;
  logic sys_clk = 0, rstn, hard_reset_n, memtest_reset_n, boot_privilege_strap;
  logic boot_security_strap, regport_wakeup, need_clock, irq_event, irq_clear, rd_done;
  logic wr_cmd_valid, wd_valid, wd_last, rd_cmd_valid, sub_clk_en, clock_gate_req;
  logic power_down_req, wr_cmd_ready, wd_ready, wr_done, rd_cmd_ready, privileged;
  logic nonsecure, clock_granted, clock_denied, power_granted, power_denied;
  logic irq_seen, wr_seen, rd_seen;
  logic [1:0]  bresp_code, wr_done_resp;
  logic [4:0]  rd_cmd_slot;
  logic [5:0]  wr_cmd_id, wr_seen_id, rd_seen_id, w_id;
  logic [7:0]  wr_cmd_len, rd_cmd_len, wd_strb;
  logic [31:0] wr_cmd_addr, rd_cmd_addr;
  logic [63:0] wd_data;
  nbi_stream_t rd_cmd_stream;
  int          n_fail = 0, checks_done = 0, k, nacc;
  // First ids, exact tops of IFM and WGT, one BIAS id, clamped slots of CMD and M2M
  nbi_row_t rows[8] = '{'{NBI_STREAM_CMD, 5'h00, 6'h00}, '{NBI_STREAM_CMD, 5'h09, 6'h03},
    '{NBI_STREAM_IFM, 5'h00, 6'h04}, '{NBI_STREAM_IFM, 5'h19, 6'h1d},
    '{NBI_STREAM_WGT, 5'h19, 6'h37}, '{NBI_STREAM_BIAS, 5'h02, 6'h3a},
    '{NBI_STREAM_M2M, 5'h00, 6'h3c}, '{NBI_STREAM_M2M, 5'h1f, 6'h3f}};
  wire [4:0] ev = {rd_seen, wr_done, clock_granted, power_denied, clock_denied};
  nbi_if bus ();
  nbi_dev_end nbi_dev_end_inst (.*, .port(bus));
  nbi_sys_end nbi_sys_end_inst (.*, .port(bus));
  nbi_assertions nbi_assertions_inst (.sys_clk, .hard_reset_n, .memtest_reset_n,
    .clock_chan_request_n(bus.clock_chan_request_n), .clock_chan_deny(bus.clock_chan_deny),
    .clock_chan_accept_n(bus.clock_chan_accept_n), .power_chan_deny(bus.power_chan_deny),
    .power_chan_request_n(bus.power_chan_request_n), .irq(bus.irq),
    .power_chan_accept_n(bus.power_chan_accept_n), .mgr0_wakeup(bus.mgr0_wakeup),
    .mgr0_clock_enable(bus.mgr0_clock_enable), .awvalid(bus.awvalid), .awready(bus.awready),
    .awaddr(bus.awaddr), .wvalid(bus.wvalid), .arvalid(bus.arvalid), .bvalid(bus.bvalid),
    .bready(bus.bready));
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (wr_seen === 1'b1) w_id <= wr_seen_id;
  task chk(input string nm, input logic [63:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Bounded: a silent end is a mismatch, not a hang
  task wait_ev(input int b);
    k = 0;
    while (ev[b] !== 1'b1 && k < 300) begin
      cyc(1);
      k++;
    end
    chk("event", 1'h1, ev[b]);
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20000 n_fail++;
    results;
  end
  initial begin
    {rstn, hard_reset_n, boot_security_strap, regport_wakeup, need_clock, irq_event} = '0;
    {irq_clear, wr_cmd_valid, wd_valid, wd_last, rd_cmd_valid, rd_done, wd_data} = '0;
    {clock_gate_req, power_down_req, wr_cmd_id, rd_cmd_slot} = '0;
    {memtest_reset_n, boot_privilege_strap, sub_clk_en} = 3'h7;
    rd_cmd_stream = NBI_STREAM_CMD;
    {wr_cmd_addr, rd_cmd_addr} = 64'h0000_1000_0000_2000;
    {wr_cmd_len, rd_cmd_len, wd_strb, bresp_code} = 26'h20_03fe;
    cyc(8);
    {rstn, hard_reset_n} = 2'h3;
    cyc(3);
    foreach (rows[i]) begin
      rd_cmd_stream = rows[i].s;
      rd_cmd_slot = rows[i].slot;
      rd_cmd_valid = 1'b1;
      while (rd_cmd_ready !== 1'b1) cyc(1);
      cyc(1);
      rd_cmd_valid = 1'b0;
      wait_ev(4);
      chk("read id", rows[i].id, rd_seen_id);
      rd_done = 1'b1;
      cyc(1);
      rd_done = 1'b0;
    end
    $display("read ids done");
    chk("privileged", 1'h1, privileged);
    chk("nonsecure", 1'h0, nonsecure);
    nacc = 0;
    repeat (14) begin
      wd_valid = 1'b1;
      wd_data = {8{nacc[7:0]}};
      wd_last = (nacc == 8);
      if (wd_ready === 1'b1) nacc++;
      cyc(1);
    end
    wd_valid = 1'b0;
    chk("beats held", 9, nacc);
    wr_cmd_id = 6'h2a;
    wr_cmd_valid = 1'b1;
    while (wr_cmd_ready !== 1'b1) cyc(1);
    cyc(1);
    wr_cmd_valid = 1'b0;
    wait_ev(3);
    cyc(1);
    chk("write resp", 2'h2, wr_done_resp);
    chk("write id", 6'h2a, w_id);
    $display("write path done");
    sub_clk_en = 1'b0;
    cyc(2);
    irq_event = 1'b1;
    cyc(1);
    {irq_event, sub_clk_en} = 2'h1;
    cyc(4);
    chk("irq frozen", 1'h0, irq_seen);
    irq_event = 1'b1;
    cyc(1);
    irq_event = 1'b0;
    cyc(3);
    chk("irq level", 1'h1, irq_seen);
    clock_gate_req = 1'b1;
    wait_ev(0);
    {clock_gate_req, irq_clear} = 2'h1;
    cyc(1);
    irq_clear = 1'b0;
    cyc(6);
    chk("irq cleared", 1'h0, irq_seen);
    clock_gate_req = 1'b1;
    wait_ev(2);
    clock_gate_req = 1'b0;
    cyc(6);
    chk("clock accept", 1'h1, bus.clock_chan_accept_n);
    {need_clock, power_down_req} = 2'h3;
    wait_ev(1);
    chk("power active", 1'h1, bus.power_chan_active);
    {need_clock, power_down_req, regport_wakeup} = 3'h1;
    cyc(6);
    chk("power deny", 1'h0, bus.power_chan_deny);
    chk("clock active", 1'h1, bus.clock_chan_active);
    chk("power idle", 1'h0, bus.power_chan_active);
    $display("handshakes done");
    {boot_privilege_strap, boot_security_strap, hard_reset_n} = 3'h2;
    #1 chk("async reset", 1'h0, bus.clock_chan_active);
    cyc(2);
    {hard_reset_n, regport_wakeup} = 2'h2;
    cyc(3);
    chk("privileged", 1'h0, privileged);
    chk("nonsecure", 1'h1, nonsecure);
    memtest_reset_n = 1'b0;
    #1 chk("memtest reset", 1'h0, rd_cmd_ready);
    cyc(2);
    memtest_reset_n = 1'b1;
    cyc(3);
    chk("ready again", 1'h1, rd_cmd_ready);
    $display("resets done");
    results;
  end
endmodule
